//--- pkg/scmi_consts.svh
// Register offsets, field positions, reset values and codes for serial mode cfg
`ifndef SCMI_CONSTS_SVH
`define SCMI_CONSTS_SVH
// Byte addresses of the register words
`define SCMI_OFF_MATCH_A    12'h000
`define SCMI_OFF_MATCH_B    12'h004
`define SCMI_OFF_IMODE      12'h008
`define SCMI_OFF_RXMODE     12'h00C
`define SCMI_OFF_CLKSEL     12'h010
`define SCMI_OFF_GENA_CFG   12'h014
`define SCMI_OFF_GENB_CFG   12'h018
`define SCMI_OFF_GENA_LO    12'h01C
`define SCMI_OFF_GENA_HI    12'h020
`define SCMI_OFF_GENB_LO    12'h024
`define SCMI_OFF_GENB_HI    12'h028
`define SCMI_OFF_PINMODE    12'h02C
`define SCMI_OFF_MODEMCTL   12'h030
`define SCMI_OFF_BLK_EN     12'h034
`define SCMI_OFF_RX_EN      12'h038
`define SCMI_OFF_TMR_EN     12'h03C
`define SCMI_OFF_MDM_EN     12'h040
`define SCMI_OFF_SUMMARY    12'h044
`define SCMI_OFF_IRQ_CODE   12'h048
`define SCMI_OFF_FIFO_LOCK  12'h04C
`define SCMI_OFF_CHAR_STAT  12'h050
// Reset values
`define SCMI_RST_BYTE       8'h00
`define SCMI_RST_PINMODE    8'h0F
// Field positions
`define SCMI_B_NETMODE      1
`define SCMI_B_PLL_DIS      2
`define SCMI_B_WIN_SEL      3
`define SCMI_B_START_SEL    4
`define SCMI_B_RX_CLK_MODE_SEL         0
`define SCMI_B_RX_CLK_SRC_SEL         1
`define SCMI_B_TX_CLK_MODE_SEL         2
`define SCMI_B_TX_CLK_SRC_SEL         3
`define SCMI_B_GEN_MODE     0
`define SCMI_B_GENA_SRC     1
`define SCMI_B_P1_DIR       0
`define SCMI_B_P1_FUNC      1
`define SCMI_B_P2_DIR       2
`define SCMI_B_P2_FUNC      3
`define SCMI_B_P3_FUNC      4
`define SCMI_B_P4_FUNC      5
`define SCMI_B_GP1          0
`define SCMI_B_GP0          1
`define SCMI_B_LOCK_SET     0
`define SCMI_B_LOCK_CLR     1
// Character classes
`define SCMI_ASCII_TOP      8'h1F
`define SCMI_ASCII_DEL      8'h7F
`define SCMI_EBCDIC_TOP     8'h3F
// Priority codes
`define SCMI_IC_TIMER       3'h5
`define SCMI_IC_TXM         3'h4
`define SCMI_IC_RXM         3'h3
`define SCMI_IC_RXF         3'h2
`define SCMI_IC_TXF         3'h1
`define SCMI_IC_MODEM       3'h0
// Block bit positions in summary and enable
`define SCMI_BK_TIMER       0
`define SCMI_BK_TXM         1
`define SCMI_BK_MODEM       2
`define SCMI_BK_RXM         3
`define SCMI_BK_TXF         4
`define SCMI_BK_RXF         5
`endif

//--- pkg/scmi_pkg.sv
// Types for the serial mode and interrupt configuration block
package scmi_pkg;
    typedef enum logic [1:0] {
        SCMI_RC_0, SCMI_RC_1, SCMI_RC_2, SCMI_RC_3
    } scmi_recog_t;
    // One received character from the shifter
    typedef struct packed {
        logic       valid;
        logic       addr_bit;
        logic [7:0] data;
    } scmi_rxchar_t;
    // Receiver sampling, receive clock and transmit clock controls
    typedef struct packed {
        logic pll_enable;
        logic wide_window;
        logic strict_start;
        logic rx_1x;
        logic rx_src_a;
        logic tx_1x;
        logic tx_src_a;
    } scmi_rxctl_t;
    // Rate generator configuration
    typedef struct packed {
        logic        baud_mode;
        logic [1:0]  src;
        logic [15:0] divisor;
    } scmi_gen_t;
endpackage : scmi_pkg

//--- logic/scmi_ctrl.sv
// Mode, pin and two-level interrupt config of an async serial controller
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "scmi_consts.svh"

module scmi_ctrl (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Received character and FIFO gating
    input  wire scmi_pkg::scmi_rxchar_t rx_char,
    output logic                      rx_store,
    output logic                      fifo_locked,
    output logic                      std_char_rcvd_flag,
    output logic                      prog_char_match_flag,
    // Receiver and generator controls
    output scmi_pkg::scmi_rxctl_t     rx_ctl,
    output scmi_pkg::scmi_gen_t       rate_gen_a,
    output scmi_pkg::scmi_gen_t       rate_gen_b,
    // Block status inputs
    input  wire logic [6:0]           rx_status,
    input  wire logic [1:0]           timer_status,
    input  wire logic [3:0]           modem_status,
    input  wire logic                 txm_req,
    input  wire logic                 txf_req,
    input  wire logic                 rxf_req,
    input  wire logic                 gen_a_out,
    input  wire logic                 gen_b_out,
    // Multifunction pins
    input  wire logic                 pin1_in,
    output logic                      pin1_out,
    output logic                      pin1_oe,
    input  wire logic                 pin2_in,
    output logic                      pin2_out,
    output logic                      pin2_oe,
    output logic                      pin4_out,
    output logic                      pin3_is_sclk,
    output logic                      carrier_in,
    output logic                      set_ready_in,
    // Interrupt code
    output logic [2:0]                top_irq_code,
    output logic                      irq_pending
);
    import scmi_pkg::*;

    // Configuration registers
    logic [7:0] match_a_ff, match_b_ff, imode_ff, rxmode_ff, clksel_ff;
    logic [7:0] gena_cfg_ff, genb_cfg_ff, gena_lo_ff, gena_hi_ff;
    logic [7:0] genb_lo_ff, genb_hi_ff, pinmode_ff, mdmctl_ff;
    logic [7:0] blk_en_ff, rx_en_ff, tmr_en_ff, mdm_en_ff;
    logic [7:0] nxt_match_a, nxt_match_b, nxt_imode, nxt_rxmode;
    logic [7:0] nxt_clksel, nxt_gena_cfg, nxt_genb_cfg, nxt_gena_lo;
    logic [7:0] nxt_gena_hi, nxt_genb_lo, nxt_genb_hi, nxt_pinmode;
    logic [7:0] nxt_mdmctl, nxt_blk_en, nxt_rx_en, nxt_tmr_en, nxt_mdm_en;
    // Bus phase capture
    logic        wr_pend_ff, nxt_wr_pend;
    logic [11:0] addr_ff, nxt_addr;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic        addr_ok;
    // Receive path state
    logic lock_ff, nxt_lock, store_ff, nxt_store;
    logic std_ff, nxt_std, prog_ff, nxt_prog;
    logic [1:0] stat_ff, nxt_stat;
    // Interrupt pipeline
    logic [5:0] summary_ff, nxt_summary;
    logic [5:0] sum_d_ff, nxt_sum_d;
    logic [2:0] code_ff, nxt_code;
    logic       pend_ff, nxt_pend;
    // Pin synchronisers, three stages
    logic [2:0] p1_sync_ff, nxt_p1_sync, p2_sync_ff, nxt_p2_sync;
    logic       p1_lvl_ff, nxt_p1_lvl, p2_lvl_ff, nxt_p2_lvl;
    logic       p1o_ff, nxt_p1o, p1oe_ff, nxt_p1oe;
    logic       p2o_ff, nxt_p2o, p2oe_ff, nxt_p2oe, p4o_ff, nxt_p4o;
    logic       p3_ff, nxt_p3;
    scmi_rxctl_t rxctl_ff, nxt_rxctl;
    scmi_gen_t   gena_ff, nxt_gena, genb_ff, nxt_genb;

    // Standard control set membership, used by the normal mode decode only
    function automatic logic is_std_ctl(input logic [1:0] code,
                                        input logic [7:0] ch);
        unique case (scmi_recog_t'(code))
            SCMI_RC_1: is_std_ctl = (ch <= `SCMI_ASCII_TOP) ||
                                    (ch == `SCMI_ASCII_DEL);
            SCMI_RC_3: is_std_ctl = (ch <= `SCMI_EBCDIC_TOP);
            SCMI_RC_0, SCMI_RC_2: is_std_ctl = 1'b0;
        endcase
    endfunction

    // Address map check, used by writes only
    function automatic logic map_hit(input logic [11:0] a);
        map_hit = (a <= `SCMI_OFF_CHAR_STAT) && (a[1:0] == 2'b00);
    endfunction

    assign addr_ok = hsel && hready && htrans[1];

    // Register writes land in the data phase after the address phase
    always_comb begin
        nxt_wr_pend  = addr_ok && hwrite && map_hit(haddr);
        nxt_addr     = addr_ok ? haddr : addr_ff;
        nxt_match_a  = match_a_ff;
        nxt_match_b  = match_b_ff;
        nxt_imode    = imode_ff;
        nxt_rxmode   = rxmode_ff;
        nxt_clksel   = clksel_ff;
        nxt_gena_cfg = gena_cfg_ff;
        nxt_genb_cfg = genb_cfg_ff;
        nxt_gena_lo  = gena_lo_ff;
        nxt_gena_hi  = gena_hi_ff;
        nxt_genb_lo  = genb_lo_ff;
        nxt_genb_hi  = genb_hi_ff;
        nxt_pinmode  = pinmode_ff;
        nxt_mdmctl   = mdmctl_ff;
        nxt_blk_en   = blk_en_ff;
        nxt_rx_en    = rx_en_ff;
        nxt_tmr_en   = tmr_en_ff;
        nxt_mdm_en   = mdm_en_ff;
        if (wr_pend_ff) begin
            unique case (addr_ff)
                `SCMI_OFF_MATCH_A:  nxt_match_a  = hwdata[7:0];
                `SCMI_OFF_MATCH_B:  nxt_match_b  = hwdata[7:0];
                `SCMI_OFF_IMODE:    nxt_imode    = hwdata[7:0];
                `SCMI_OFF_RXMODE:   nxt_rxmode   = hwdata[7:0];
                `SCMI_OFF_CLKSEL:   nxt_clksel   = hwdata[7:0];
                `SCMI_OFF_GENA_CFG: nxt_gena_cfg = hwdata[7:0];
                `SCMI_OFF_GENB_CFG: nxt_genb_cfg = hwdata[7:0];
                `SCMI_OFF_GENA_LO:  nxt_gena_lo  = hwdata[7:0];
                `SCMI_OFF_GENA_HI:  nxt_gena_hi  = hwdata[7:0];
                `SCMI_OFF_GENB_LO:  nxt_genb_lo  = hwdata[7:0];
                `SCMI_OFF_GENB_HI:  nxt_genb_hi  = hwdata[7:0];
                `SCMI_OFF_PINMODE:  nxt_pinmode  = hwdata[7:0];
                `SCMI_OFF_MODEMCTL: nxt_mdmctl   = hwdata[7:0];
                `SCMI_OFF_BLK_EN:   nxt_blk_en   = hwdata[7:0];
                `SCMI_OFF_RX_EN:    nxt_rx_en    = hwdata[7:0];
                `SCMI_OFF_TMR_EN:   nxt_tmr_en   = hwdata[7:0];
                `SCMI_OFF_MDM_EN:   nxt_mdm_en   = hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data computed in the address phase, presented in data phase
    always_comb begin
        nxt_hrdata = hrdata_ff;
        if (addr_ok && !hwrite) begin
            nxt_hrdata = 32'h0000_0000;
            unique case (haddr)
                `SCMI_OFF_MATCH_A:  nxt_hrdata[7:0] = match_a_ff;
                `SCMI_OFF_MATCH_B:  nxt_hrdata[7:0] = match_b_ff;
                `SCMI_OFF_IMODE:    nxt_hrdata[7:0] = imode_ff;
                `SCMI_OFF_RXMODE:   nxt_hrdata[7:0] = rxmode_ff;
                `SCMI_OFF_CLKSEL:   nxt_hrdata[7:0] = clksel_ff;
                `SCMI_OFF_GENA_CFG: nxt_hrdata[7:0] = gena_cfg_ff;
                `SCMI_OFF_GENB_CFG: nxt_hrdata[7:0] = genb_cfg_ff;
                `SCMI_OFF_GENA_LO:  nxt_hrdata[7:0] = gena_lo_ff;
                `SCMI_OFF_GENA_HI:  nxt_hrdata[7:0] = gena_hi_ff;
                `SCMI_OFF_GENB_LO:  nxt_hrdata[7:0] = genb_lo_ff;
                `SCMI_OFF_GENB_HI:  nxt_hrdata[7:0] = genb_hi_ff;
                `SCMI_OFF_PINMODE:  nxt_hrdata[7:0] = pinmode_ff;
                `SCMI_OFF_MODEMCTL: nxt_hrdata[7:0] = mdmctl_ff;
                `SCMI_OFF_BLK_EN:   nxt_hrdata[7:0] = blk_en_ff;
                `SCMI_OFF_RX_EN:    nxt_hrdata[7:0] = rx_en_ff;
                `SCMI_OFF_TMR_EN:   nxt_hrdata[7:0] = tmr_en_ff;
                `SCMI_OFF_MDM_EN:   nxt_hrdata[7:0] = mdm_en_ff;
                `SCMI_OFF_SUMMARY:  nxt_hrdata[5:0] = summary_ff;
                `SCMI_OFF_IRQ_CODE: nxt_hrdata[3:0] = {pend_ff, code_ff};
                `SCMI_OFF_FIFO_LOCK: nxt_hrdata[0]  = lock_ff;
                `SCMI_OFF_CHAR_STAT: nxt_hrdata[1:0] = stat_ff;
                default: ;
            endcase
        end
    end

    // Character recognition and FIFO lock; under codes 01 and 10 software lock writes
    // lose to an address character in the same cycle so no event is lost
    always_comb begin
        logic netm, is_match, is_addr, std_hit;
        logic [1:0] rc;
        netm     = imode_ff[`SCMI_B_NETMODE];
        rc       = rxmode_ff[1:0];
        is_match = (rx_char.data == match_a_ff) ||
                   (rx_char.data == match_b_ff);
        is_addr  = rx_char.valid && rx_char.addr_bit;
        std_hit  = rx_char.valid && is_std_ctl(rc, rx_char.data);
        nxt_lock = lock_ff;
        if (wr_pend_ff && addr_ff == `SCMI_OFF_FIFO_LOCK) begin
            if (hwdata[`SCMI_B_LOCK_SET])
                nxt_lock = 1'b1;
            else if (hwdata[`SCMI_B_LOCK_CLR])
                nxt_lock = 1'b0;
        end
        nxt_std   = 1'b0;
        nxt_prog  = 1'b0;
        nxt_store = 1'b0;
        if (netm) begin
            nxt_std  = is_addr;
            nxt_prog = is_addr && is_match;
            if (is_addr) begin
                unique case (scmi_recog_t'(rc))
                    SCMI_RC_1: nxt_lock = 1'b0;
                    SCMI_RC_2: nxt_lock = !is_match;
                    SCMI_RC_0, SCMI_RC_3: ;
                endcase
            end
            // Address characters always stored in codes 00 and 01
            if (is_addr)
                nxt_store = (rc == 2'b00) || (rc == 2'b01) ||
                            (rc == 2'b10 && is_match);
            else
                nxt_store = rx_char.valid && !lock_ff;
        end else begin
            nxt_std   = std_hit;
            nxt_prog  = rx_char.valid && is_match;
            nxt_store = rx_char.valid;
        end
        nxt_stat = rx_char.valid ? {nxt_prog, nxt_std} : stat_ff; // Held to poll
    end

    // Receiver and generator control decode
    always_comb begin
        nxt_rxctl.pll_enable   = !rxmode_ff[`SCMI_B_PLL_DIS];
        nxt_rxctl.wide_window  = rxmode_ff[`SCMI_B_WIN_SEL];
        nxt_rxctl.strict_start = rxmode_ff[`SCMI_B_START_SEL];
        nxt_rxctl.rx_1x        = clksel_ff[`SCMI_B_RX_CLK_MODE_SEL];
        nxt_rxctl.rx_src_a     = clksel_ff[`SCMI_B_RX_CLK_SRC_SEL];
        nxt_rxctl.tx_1x        = clksel_ff[`SCMI_B_TX_CLK_MODE_SEL];
        nxt_rxctl.tx_src_a     = clksel_ff[`SCMI_B_TX_CLK_SRC_SEL];
        // Timer mode forces system clock source, code 00
        nxt_gena.baud_mode = gena_cfg_ff[`SCMI_B_GEN_MODE];
        nxt_gena.src = gena_cfg_ff[`SCMI_B_GEN_MODE] ?
            {1'b0, gena_cfg_ff[`SCMI_B_GENA_SRC]} : 2'b00;
        nxt_gena.divisor = {gena_hi_ff, gena_lo_ff};
        nxt_genb.baud_mode = genb_cfg_ff[`SCMI_B_GEN_MODE];
        // Reserved source 11 falls back to system clock
        nxt_genb.src = (genb_cfg_ff[`SCMI_B_GEN_MODE] &&
            genb_cfg_ff[2:1] != 2'b11) ? genb_cfg_ff[2:1] : 2'b00;
        nxt_genb.divisor = {genb_hi_ff, genb_lo_ff};
    end

    // Multifunction pins; inputs pass three flops, change on agreement
    always_comb begin
        nxt_p1_sync = {p1_sync_ff[1:0], pin1_in};
        nxt_p2_sync = {p2_sync_ff[1:0], pin2_in};
        nxt_p1_lvl  = (p1_sync_ff[2] == p1_sync_ff[1]) ?
                      p1_sync_ff[2] : p1_lvl_ff;
        nxt_p2_lvl  = (p2_sync_ff[2] == p2_sync_ff[1]) ?
                      p2_sync_ff[2] : p2_lvl_ff;
        nxt_p1oe = !pinmode_ff[`SCMI_B_P1_DIR];
        nxt_p2oe = !pinmode_ff[`SCMI_B_P2_DIR];
        // System clock seen as toggle of a flop, half rate limitation
        nxt_p1o = pinmode_ff[`SCMI_B_P1_FUNC] ?
                  mdmctl_ff[`SCMI_B_GP1] : !p1o_ff;
        nxt_p2o = pinmode_ff[`SCMI_B_P2_FUNC] ?
                  mdmctl_ff[`SCMI_B_GP0] : gen_a_out;
        nxt_p3  = !pinmode_ff[`SCMI_B_P3_FUNC];
        nxt_p4o = pinmode_ff[`SCMI_B_P4_FUNC] ?
                  mdmctl_ff[`SCMI_B_GP0] : gen_b_out;
    end

    // Two-level masking and priority; code trails summary by two edges
    always_comb begin
        nxt_summary[`SCMI_BK_TIMER] = |(timer_status & tmr_en_ff[1:0]);
        nxt_summary[`SCMI_BK_TXM]   = txm_req;
        nxt_summary[`SCMI_BK_MODEM] = |(modem_status & mdm_en_ff[3:0]);
        nxt_summary[`SCMI_BK_RXM]   = |(rx_status & rx_en_ff[6:0]);
        nxt_summary[`SCMI_BK_TXF]   = txf_req;
        nxt_summary[`SCMI_BK_RXF]   = rxf_req;
        nxt_sum_d = summary_ff & blk_en_ff[5:0];
        nxt_pend  = |sum_d_ff;
        if (sum_d_ff[`SCMI_BK_TIMER])      nxt_code = `SCMI_IC_TIMER;
        else if (sum_d_ff[`SCMI_BK_TXM])   nxt_code = `SCMI_IC_TXM;
        else if (sum_d_ff[`SCMI_BK_RXM])   nxt_code = `SCMI_IC_RXM;
        else if (sum_d_ff[`SCMI_BK_RXF])   nxt_code = `SCMI_IC_RXF;
        else if (sum_d_ff[`SCMI_BK_TXF])   nxt_code = `SCMI_IC_TXF;
        else                               nxt_code = `SCMI_IC_MODEM;
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_a_ff  <= `SCMI_RST_BYTE;
            match_b_ff  <= `SCMI_RST_BYTE;
            imode_ff    <= `SCMI_RST_BYTE;
            rxmode_ff   <= `SCMI_RST_BYTE;
            clksel_ff   <= `SCMI_RST_BYTE;
            gena_cfg_ff <= `SCMI_RST_BYTE;
            genb_cfg_ff <= `SCMI_RST_BYTE;
            gena_lo_ff  <= `SCMI_RST_BYTE;
            gena_hi_ff  <= `SCMI_RST_BYTE;
            genb_lo_ff  <= `SCMI_RST_BYTE;
            genb_hi_ff  <= `SCMI_RST_BYTE;
            pinmode_ff  <= `SCMI_RST_PINMODE;
            mdmctl_ff   <= `SCMI_RST_BYTE;
            blk_en_ff   <= `SCMI_RST_BYTE;
            rx_en_ff    <= `SCMI_RST_BYTE;
            tmr_en_ff   <= `SCMI_RST_BYTE;
            mdm_en_ff   <= `SCMI_RST_BYTE;
            wr_pend_ff  <= 1'b0;
            addr_ff     <= 12'h000;
            hrdata_ff   <= 32'h0000_0000;
            lock_ff     <= 1'b0;
            store_ff    <= 1'b0;
            std_ff      <= 1'b0;
            prog_ff     <= 1'b0;
            stat_ff     <= 2'h0;
            summary_ff  <= 6'h00;
            sum_d_ff    <= 6'h00;
            code_ff     <= `SCMI_IC_MODEM;
            pend_ff     <= 1'b0;
            p1_sync_ff  <= 3'h0;
            p2_sync_ff  <= 3'h0;
            p1_lvl_ff   <= 1'b0;
            p2_lvl_ff   <= 1'b0;
            p1o_ff      <= 1'b0;
            p1oe_ff     <= 1'b0;
            p2o_ff      <= 1'b0;
            p2oe_ff     <= 1'b0;
            p3_ff       <= 1'b1;
            p4o_ff      <= 1'b0;
            rxctl_ff    <= '{pll_enable: 1'b1, default: 1'b0};
            gena_ff     <= '0;
            genb_ff     <= '0;
        end else begin
            match_a_ff  <= nxt_match_a;
            match_b_ff  <= nxt_match_b;
            imode_ff    <= nxt_imode;
            rxmode_ff   <= nxt_rxmode;
            clksel_ff   <= nxt_clksel;
            gena_cfg_ff <= nxt_gena_cfg;
            genb_cfg_ff <= nxt_genb_cfg;
            gena_lo_ff  <= nxt_gena_lo;
            gena_hi_ff  <= nxt_gena_hi;
            genb_lo_ff  <= nxt_genb_lo;
            genb_hi_ff  <= nxt_genb_hi;
            pinmode_ff  <= nxt_pinmode;
            mdmctl_ff   <= nxt_mdmctl;
            blk_en_ff   <= nxt_blk_en;
            rx_en_ff    <= nxt_rx_en;
            tmr_en_ff   <= nxt_tmr_en;
            mdm_en_ff   <= nxt_mdm_en;
            wr_pend_ff  <= nxt_wr_pend;
            addr_ff     <= nxt_addr;
            hrdata_ff   <= nxt_hrdata;
            lock_ff     <= nxt_lock;
            store_ff    <= nxt_store;
            std_ff      <= nxt_std;
            prog_ff     <= nxt_prog;
            stat_ff     <= nxt_stat;
            summary_ff  <= nxt_summary;
            sum_d_ff    <= nxt_sum_d;
            code_ff     <= nxt_code;
            pend_ff     <= nxt_pend;
            p1_sync_ff  <= nxt_p1_sync;
            p2_sync_ff  <= nxt_p2_sync;
            p1_lvl_ff   <= nxt_p1_lvl;
            p2_lvl_ff   <= nxt_p2_lvl;
            p1o_ff      <= nxt_p1o;
            p1oe_ff     <= nxt_p1oe;
            p2o_ff      <= nxt_p2o;
            p2oe_ff     <= nxt_p2oe;
            p3_ff       <= nxt_p3;
            p4o_ff      <= nxt_p4o;
            rxctl_ff    <= nxt_rxctl;
            gena_ff     <= nxt_gena;
            genb_ff     <= nxt_genb;
        end
    end

    // Outputs straight from flops; zero wait, always OKAY
    assign hrdata               = hrdata_ff;
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign rx_store             = store_ff;
    assign fifo_locked          = lock_ff;
    assign std_char_rcvd_flag   = std_ff;
    assign prog_char_match_flag = prog_ff;
    assign rx_ctl               = rxctl_ff;
    assign rate_gen_a           = gena_ff;
    assign rate_gen_b           = genb_ff;
    assign pin1_out             = p1o_ff;
    assign pin1_oe              = p1oe_ff;
    assign pin2_out             = p2o_ff;
    assign pin2_oe              = p2oe_ff;
    assign pin4_out             = p4o_ff;
    assign pin3_is_sclk         = p3_ff;
    assign carrier_in           = p1_lvl_ff;
    assign set_ready_in         = p2_lvl_ff;
    assign top_irq_code         = code_ff;
    assign irq_pending          = pend_ff;
endmodule // scmi_ctrl

//--- sim/scmi_chk.sv
// Checker of character, generator and interrupt outputs
`timescale 1ns/100ps
module scmi_chk (
    // Clock and reset
    input logic                   hclk, hresetn,
    // Character side
    input scmi_pkg::scmi_rxchar_t rx_char,
    input logic                   rx_store, std_char_rcvd_flag,
    input logic                   prog_char_match_flag,
    // Generators
    input scmi_pkg::scmi_gen_t    rate_gen_a, rate_gen_b,
    // Requests and code
    input logic [6:0]             rx_status,
    input logic [1:0]             timer_status,
    input logic [3:0]             modem_status,
    input logic                   txm_req, txf_req, rxf_req,
    input logic [2:0]             top_irq_code,
    input logic                   irq_pending
);
    import scmi_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Any raw request, masked or not
    wire req = |{rx_status, timer_status, modem_status, txm_req, txf_req,
                 rxf_req};
    property p_store; rx_store |-> $past(rx_char.valid); endproperty
    a_store: assert property (p_store) else $error("stray store");
    property p_std; std_char_rcvd_flag |-> $past(rx_char.valid); endproperty
    a_std: assert property (p_std) else $error("stray std flag");
    property p_prog; prog_char_match_flag |-> $past(rx_char.valid);
    endproperty
    a_prog: assert property (p_prog) else $error("stray match");
    property p_gena; !rate_gen_a.baud_mode |-> rate_gen_a.src == 2'h0;
    endproperty
    a_gena: assert property (p_gena) else $error("gen a src");
    property p_genb; !rate_gen_b.baud_mode |-> rate_gen_b.src == 2'h0;
    endproperty
    a_genb: assert property (p_genb) else $error("gen b src");
    property p_bres; rate_gen_b.src != 2'h3; endproperty
    a_bres: assert property (p_bres) else $error("gen b reserved");
    property p_code; top_irq_code <= 3'h5; endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_pend; $rose(irq_pending) |-> $past(req, 3); endproperty
    a_pend: assert property (p_pend) else $error("pending early");
    c_store: cover property (rx_store);
    c_pend: cover property (irq_pending && top_irq_code == 3'h5);
    c_baud: cover property (rate_gen_b.baud_mode);
endmodule // scmi_chk
bind scmi_ctrl scmi_chk u_chk (.*);

//--- sim/scmi_peer.sv
// Remote station model handing received characters to the block
`timescale 1ns/100ps
module scmi_peer (
    input wire logic              hclk,
    output scmi_pkg::scmi_rxchar_t rx_char
);
    initial rx_char = '0;
    // One clock-aligned char, then inverted junk so stale data never matches
    task automatic send(input logic a, input logic [7:0] d);
        @(posedge hclk);
        rx_char <= '{1'b1, a, d};
        @(posedge hclk);
        rx_char <= '{1'b0, ~a, ~d};
        repeat (2) @(posedge hclk);
    endtask
endmodule // scmi_peer

//--- sim/scmi_ctrl_tb.sv
// Bench: register reads checked against a queue of expected words
`timescale 1ns/100ps
`define CK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module scmi_ctrl_tb;
    import scmi_pkg::*;
    logic hclk, hresetn, hsel, hwrite, rd_ph, hreadyout, hresp, rx_store;
    logic fifo_locked, std_char_rcvd_flag, prog_char_match_flag, pin1_out;
    logic pin1_oe, pin2_out, pin2_oe, pin4_out, pin3_is_sclk, carrier_in;
    logic set_ready_in, irq_pending, txm_req, txf_req, rxf_req, pin1_in;
    logic pin2_in, gen_a_out, gen_b_out;
    logic [11:0] haddr;
    logic [1:0] htrans, timer_status;
    logic [2:0] hsize, top_irq_code;
    logic [31:0] hwdata, hrdata, x, eq[$];
    logic [6:0] rx_status;
    logic [3:0] modem_status;
    logic [7:0] r, ic[6] = '{5, 4, 0, 3, 1, 2};
    logic [11:0] offs[6] = '{0, 4, 12'h1C, 12'h20, 12'h24, 12'h28};
    logic [23:0] tv[6] = '{24'h011F01, 24'h012000, 24'h017F01,
                           24'h033F01, 24'h034000, 24'h000500};
    logic [23:0] nv[4] = '{24'h02A503, 24'h021111, 24'h011101, 24'h002201};
    scmi_rxchar_t rx_char;
    scmi_rxctl_t rx_ctl;
    scmi_gen_t rate_gen_a, rate_gen_b;
    int fails, compares;
    scmi_ctrl u_dut (.*, .hready(hreadyout));
    scmi_peer u_peer (.hclk(hclk), .rx_char(rx_char));
    initial begin
        hclk = 0;
        forever #5 hclk = ~hclk;
    end
    // One single transfer; a read notes its expected word
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [7:0] e);
        {hsel, htrans, hwrite, haddr} <= {3'h6, w, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {htrans, hwdata, rd_ph} <= {2'h0, 24'h0, d, !w};
        if (!w) eq.push_back({24'h0, e});
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph <= 0;
    endtask
    always @(posedge hclk) if (rd_ph === 1'b1) begin
        x = eq.pop_front();
        `CK(hrdata, x)
    end
    task automatic test_done;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000 fails++;
        test_done;
    end
    initial begin
        void'($urandom(32'h53E309D4));
        {hresetn, hsel, htrans, hwrite, haddr, hwdata, rd_ph} = '0;
        {rx_status, modem_status, timer_status, txm_req, txf_req} = '0;
        {rxf_req, hsize} = 4'h2;
        {pin1_in, pin2_in, gen_a_out, gen_b_out} = 4'($urandom);
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        bus(0, 12'h02C, 0, 8'h0F);
        bus(0, 12'h0FC, 0, 8'h00);
        foreach (offs[i]) begin
            r = 8'($urandom);
            bus(1, offs[i], r, 0);
            bus(0, offs[i], 0, r);
        end
        bus(1, 12'h000, 8'hA5, 0);
        r = 8'hC0 | 8'($urandom);
        bus(1, 12'h004, r, 0);
        // Normal mode: standard sets, then the B match register
        foreach (tv[i]) begin
            bus(1, 12'h00C, tv[i][23:16], 0);
            u_peer.send(0, tv[i][15:8]);
            bus(0, 12'h050, 0, tv[i][7:0]);
        end
        u_peer.send(0, r);
        bus(0, 12'h050, 0, 8'h02);
        // Network mode: lock follows code and address
        bus(1, 12'h008, 8'h02, 0);
        foreach (nv[i]) begin
            bus(1, 12'h00C, nv[i][23:16], 0);
            u_peer.send(1, nv[i][15:8]);
            bus(0, 12'h04C, 0, {7'h0, nv[i][4]});
            bus(0, 12'h050, 0, {4'h0, nv[i][3:0]});
        end
        bus(1, 12'h04C, 8'h01, 0);
        bus(0, 12'h04C, 0, 8'h01);
        // One request at a time, then all with timer masked
        foreach (offs[i]) bus(1, 12'(12'h034 + 4 * i), 8'h7F, 0);
        for (int k = 0; k < 7; k++) begin
            {rxf_req, txf_req, rx_status[0], modem_status[0], txm_req,
             timer_status[0]} <= (k < 6) ? 6'h1 << k : 6'h3F;
            if (k == 6) bus(1, 12'h034, 8'h3E, 0);
            repeat (3) @(posedge hclk);
            bus(0, 12'h048, 0, (k < 6) ? 8'h08 | ic[k] : 8'h0C);
        end
        r = 8'($urandom);
        bus(1, 12'h010, r, 0);
        bus(1, 12'h02C, 8'h30, 0);
        repeat (3) @(posedge hclk);
        `CK(pin1_oe, 1'b1)
        `CK(rx_ctl, {3'b100, r[0], r[1], r[2], r[3]})
        `CK(pin2_out, gen_a_out)
        `CK(pin3_is_sclk, 1'b0)
        `CK(pin4_out, 1'b0)
        test_done;
    end
endmodule // scmi_ctrl_tb
